// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import osc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reset_was_por = 1'b1;
  config_word_one_s cfg = '{3'h2, 2'h2, 3'h5, 3'h3, 2'h2, 1'b1};
  osc_status_s status = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, ref_trim, rd_data;
  logic pready, pslverr, switch_busy, secondary_osc_ready, periph_clk_en;
  logic usb_pll_lock_flag, system_pll_lock_flag, periph_divisor_ready, rd_err;
  osc_ctrl_s ctrl;
  logic [2:0] current_oscillator;
  logic [8:0] pll_out_div_ratio, fast_rc_div_ratio;
  logic [4:0] pll_mult_ratio;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  oscillator_clock_select_control oscillator_clock_select_control_i (
    .clk(clk), .rst(rst), .reset_was_por(reset_was_por), .cfg(cfg), .status(status),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctrl(ctrl),
    .current_oscillator(current_oscillator), .switch_busy(switch_busy),
    .secondary_osc_ready(secondary_osc_ready), .usb_pll_lock_flag(usb_pll_lock_flag),
    .system_pll_lock_flag(system_pll_lock_flag), .periph_divisor_ready(periph_divisor_ready),
    .pll_out_div_ratio(pll_out_div_ratio), .fast_rc_div_ratio(fast_rc_div_ratio),
    .pll_mult_ratio(pll_mult_ratio), .periph_clk_en(periph_clk_en), .ref_ctrl(),
    .tuning(), .ref_trim(ref_trim)
  );

  task automatic close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a hung handshake or wait ends the run here
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk); // the write lands at the ready edge, so let it settle before any look
  endtask

  task automatic rd(input string name, input logic [15:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, exp, rd_data & m);
  endtask

  // control writes only land after the two-key sequence
  task automatic unlocked_wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, UNLOCK_ADDR, UNLOCK_KEY1);
    apb(1'b1, UNLOCK_ADDR, UNLOCK_KEY2);
    apb(1'b1, a, d);
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset_por;
    rd("osc_ctrl_por", OSC_CTRL_ADDR, 32'hFFFF_FFFF, 32'h1935_2202);
    chk("fast_ratio", 32'h2, fast_rc_div_ratio);
  endtask

  task automatic t_unlock;
    apb(1'b1, OSC_CTRL_ADDR + 16'h8, 32'h10);
    chk("sleep_locked_out", 32'h0, ctrl.sleep_on_wait_enable);
    unlocked_wr(OSC_CTRL_ADDR + 16'h8, 32'h10);
    chk("sleep_set", 32'h1, ctrl.sleep_on_wait_enable);
    apb(1'b1, OSC_CTRL_ADDR + 16'h4, 32'h10);
    chk("unlock_consumed", 32'h1, ctrl.sleep_on_wait_enable);
  endtask

  task automatic t_alias;
    apb(1'b1, REF_TRIM_ADDR, 32'hFFFF_FFFF);
    rd("trim_mask", REF_TRIM_ADDR, 32'hFFFF_FFFF, REF_TRIM_MASK);
    apb(1'b1, REF_TRIM_ADDR + 16'h4, 32'h8000_0000);
    rd("trim_clr", REF_TRIM_ADDR, 32'hFFFF_FFFF, 32'h7F80_0000);
    apb(1'b1, REF_TRIM_ADDR + 16'hC, 32'hC000_0000);
    chk("trim_inv", 32'hBF80_0000, ref_trim);
    apb(1'b1, REF_TRIM_ADDR + 16'h8, 32'h4000_0000);
    rd("trim_set", REF_TRIM_ADDR, 32'hFFFF_FFFF, 32'hFF80_0000);
    unlocked_wr(TUNING_ADDR, 32'hFFFF_FFFF);
    rd("tuning_mask", TUNING_ADDR, 32'hFFFF_FFFF, 32'h0000_003F);
    apb(1'b1, REF_CTRL_ADDR, 32'hFFFF_FFFF);
    rd("ref_mask", REF_CTRL_ADDR, 32'hFFFF_FFFF, 32'h7FFF_B80F);
    apb(1'b0, 16'hF050, 32'h0);
    chk("unmapped_err", 32'h1, rd_err);
    chk("unmapped_data", 32'h0, rd_data);
  endtask

  task automatic t_ratios;
    logic [31:0] w;
    for (int c = 0; c < 8; c++) begin
      w = (c << 27) | (c << 24) | (32'h2 << 19) | (c << 16) | 32'h0000_0202;
      unlocked_wr(OSC_CTRL_ADDR, w);
      repeat (2) @(posedge clk);
      chk("pll_div", (c == 7) ? 32'd256 : (32'd1 << c), pll_out_div_ratio);
      chk("fast_div", (c == 7) ? 32'd256 : (32'd1 << c), fast_rc_div_ratio);
      chk("pll_mult", (c == 7) ? 32'd24 : (32'd15 + c), pll_mult_ratio);
    end
  endtask

  task automatic t_periph_bus_divisor;
    int n;
    for (int c = 0; c < 4; c++) begin
      unlocked_wr(OSC_CTRL_ADDR, 32'h0000_0202 | (c << 19));
      n = 0;
      while (periph_divisor_ready !== 1'b1 && n < 20) begin
        @(posedge clk);
        n++;
      end
      // every code differs from the one before it, so each write starts a busy window
      chk("div_ready_low", 32'd8, n);
      n = 0;
      do @(posedge clk); while (periph_clk_en !== 1'b1 && ++n < 20);
      n = 0;
      do begin @(posedge clk); n++; end while (periph_clk_en !== 1'b1 && n < 20);
      chk("pclk_period", 32'd1 << c, n);
    end
  endtask

  task automatic t_lock;
    unlocked_wr(OSC_CTRL_ADDR + 16'h8, 32'h80);
    unlocked_wr(OSC_CTRL_ADDR + 16'h8, 32'h100);
    chk("new_osc_locked", 32'h2, ctrl.new_oscillator);
    unlocked_wr(OSC_CTRL_ADDR + 16'h4, 32'h80);
    unlocked_wr(OSC_CTRL_ADDR + 16'h8, 32'h100);
    chk("new_osc_unlocked", 32'h3, ctrl.new_oscillator);
  endtask

  task automatic t_switch;
    int n;
    unlocked_wr(OSC_CTRL_ADDR + 16'h8, 32'h1);
    repeat (4) @(posedge clk);
    chk("cur_osc_held", 32'h2, current_oscillator);
    rd("switch_pending", OSC_CTRL_ADDR, 32'h7001, 32'h2001);
    status.target_osc_ready <= 1'b1;
    n = 0;
    do @(posedge clk); while (switch_busy !== 1'b0 && ++n < 50);
    @(posedge clk);
    rd("switch_done", OSC_CTRL_ADDR, 32'h7001, 32'h3000);
    status.target_osc_ready <= 1'b0;
  endtask

  task automatic t_status;
    @(posedge clk);
    status <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    repeat (3) @(posedge clk);
    rd("flags_on", OSC_CTRL_ADDR, 32'h0040_0068, 32'h0040_0068);
    status <= '0;
    repeat (3) @(posedge clk);
    rd("flags_off", OSC_CTRL_ADDR, 32'h0040_0068, 32'h0000_0008);
    chk("sosc_ready_port", 32'h0, secondary_osc_ready);
    unlocked_wr(OSC_CTRL_ADDR + 16'h4, 32'h0000_000A);
    status.sosc_stable <= 1'b1;
    repeat (3) @(posedge clk);
    chk("sosc_off", 32'h0, secondary_osc_ready);
    chk("fail_cleared", 32'h0, ctrl.clock_fail_flag);
  endtask

  task automatic t_nonpor;
    reset_was_por <= 1'b0;
    cfg.config_switch_monitor <= 2'h0;
    do_reset();
    rd("osc_ctrl_warm", OSC_CTRL_ADDR, 32'hFFBF_FFFF, 32'h0138_2200);
    unlocked_wr(OSC_CTRL_ADDR + 16'h8, 32'h80);
    unlocked_wr(OSC_CTRL_ADDR + 16'h8, 32'h100);
    chk("never_locked", 32'h3, ctrl.new_oscillator);
  endtask

  initial begin
    do_reset();
    t_reset_por();
    t_unlock();
    t_alias();
    t_ratios();
    t_periph_bus_divisor();
    t_lock();
    t_switch();
    t_status();
    t_nonpor();
    close_out();
  end
endmodule

// ### verilog/osc_pkg.sv
package osc_pkg;

  // register byte addresses; each one except UNLOCK_ADDR has clear/set/invert aliases above it
  localparam logic [15:0] OSC_CTRL_ADDR = 16'hF000;
  localparam logic [15:0] TUNING_ADDR = 16'hF010;
  localparam logic [15:0] REF_CTRL_ADDR = 16'hF020;
  localparam logic [15:0] REF_TRIM_ADDR = 16'hF030;
  localparam logic [15:0] UNLOCK_ADDR = 16'hF040;

  // alias selector taken from address bits 3:2
  localparam logic [1:0] ALIAS_NONE = 2'h0;
  localparam logic [1:0] ALIAS_CLR = 2'h1;
  localparam logic [1:0] ALIAS_SET = 2'h2;
  localparam logic [1:0] ALIAS_INV = 2'h3;

  // unlock keys, values are arbitrary
  localparam logic [31:0] UNLOCK_KEY1 = 32'h0000_C0DE;
  localparam logic [31:0] UNLOCK_KEY2 = 32'h0000_F00D;

  // implemented bits of the plain storage registers
  localparam logic [31:0] REF_CTRL_MASK = 32'h7FFF_BA0F;
  localparam logic [31:0] TUNING_MASK = 32'h0000_003F;
  localparam logic [31:0] REF_TRIM_MASK = 32'hFF80_0000;
  localparam int REF_DIVSW_BIT = 9;

  // oscillator control field positions
  localparam int POS_PLL_DIV = 27;
  localparam int POS_FAST_DIV = 24;
  localparam int POS_SOSC_READY = 22;
  localparam int POS_DIV_READY = 21;
  localparam int POS_PB_DIV = 19;
  localparam int POS_PLL_MULT = 16;
  localparam int POS_CUR_OSC = 12;
  localparam int POS_NEW_OSC = 8;
  localparam int POS_LOCK = 7;
  localparam int POS_USB_LOCK = 6;
  localparam int POS_SYS_LOCK = 5;
  localparam int POS_SLEEP = 4;
  localparam int POS_FAIL = 3;
  localparam int POS_USB_RC = 2;
  localparam int POS_SOSC_ON = 1;
  localparam int POS_SWITCH = 0;

  // values after reset where no configuration bit applies
  localparam logic [2:0] FAST_DIV_RESET = 3'h1;
  localparam logic [1:0] PB_DIV_RESET = 2'h3;
  localparam logic [2:0] PLL_DIV_RESET = 3'h0;
  localparam logic [2:0] PLL_MULT_RESET = 3'h0;
  localparam logic [2:0] CUR_OSC_RESET = 3'h0;

  // cycles the peripheral divisor stays busy after a change
  localparam logic [3:0] PB_DIV_SETTLE_CYCLES = 4'h8;

  typedef struct packed {
    logic [2:0] config_oscillator_select;
    logic [1:0] config_switch_monitor;
    logic [2:0] pll_mult;
    logic [2:0] pll_odiv;
    logic [1:0] pb_div;
    logic sosc_en;
  } config_word_one_s;

  typedef struct packed {
    logic sosc_stable;
    logic sys_pll_locked;
    logic usb_pll_locked;
    logic clock_fail_detect;
    logic target_osc_ready;
  } osc_status_s;

  typedef struct packed {
    logic [2:0] pll_output_divider;
    logic [2:0] fast_rc_divider;
    logic [1:0] periph_bus_divisor;
    logic [2:0] pll_multiplier;
    logic [2:0] new_oscillator;
    logic clock_select_lock;
    logic sleep_on_wait_enable;
    logic clock_fail_flag;
    logic usb_rc_clock_enable;
    logic secondary_osc_enable;
    logic switch_enable;
  } osc_ctrl_s;

  typedef enum logic [1:0] {st_idle, st_wait, st_commit} switch_state_e;

  // power-of-two divide ratio, code 7 jumps to 256
  function automatic logic [8:0] div_ratio(input logic [2:0] code);
    logic [8:0] r;
    r = 9'h001;
    case (code)
      3'h0: r = 9'h001;
      3'h1: r = 9'h002;
      3'h2: r = 9'h004;
      3'h3: r = 9'h008;
      3'h4: r = 9'h010;
      3'h5: r = 9'h020;
      3'h6: r = 9'h040;
      default: r = 9'h100;
    endcase
    return r;
  endfunction

  // multiplier 15..21, code 7 jumps to 24
  function automatic logic [4:0] mult_ratio(input logic [2:0] code);
    logic [4:0] r;
    r = 5'h0F;
    if (code == 3'h7) begin
      r = 5'h18;
    end else begin
      r = 5'h0F + {2'h0, code};
    end
    return r;
  endfunction

endpackage

// ### verilog/oscillator_clock_select_control.sv
`timescale 1ns/1ps
// Overview of operation
// - pll output divider codes give 1..64, 256
// - fast rc divider same ratios, resets to two
// - secondary ready only while running stable
// - divisor writes refused while divisor ready low
// - peripheral clock is system clock /1/2/4/8
// - pll multiplier codes give 15..21, 24
// - current oscillator reports active source encoding
// - new oscillator loads config select on reset
// - lock bit freezes selections when monitor 1x
// - monitor 0x means selections never locked
// - usb pll lock flag mirrors lock state
// - system pll lock flag mirrors lock state
// - sleep enable picks sleep or idle on wait
// - control writes need unlock sequence first
// - clear, set, invert aliases at 4, 8, C
// - unimplemented bits always read zero
// - reset values follow config and reset type
// - switch enable starts switch, clears when done
// - clock fail flag set on detected failure
// - secondary enable bit turns oscillator on
module oscillator_clock_select_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_was_por,
  input wire osc_pkg::config_word_one_s cfg,
  input wire osc_pkg::osc_status_s status,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output osc_pkg::osc_ctrl_s ctrl,
  output logic [2:0] current_oscillator,
  output logic switch_busy,
  output logic secondary_osc_ready,
  output logic usb_pll_lock_flag,
  output logic system_pll_lock_flag,
  output logic periph_divisor_ready,
  output logic [8:0] pll_out_div_ratio,
  output logic [8:0] fast_rc_div_ratio,
  output logic [4:0] pll_mult_ratio,
  output logic periph_clk_en,
  output logic [31:0] ref_ctrl,
  output logic [31:0] tuning,
  output logic [31:0] ref_trim
);
  import osc_pkg::*;

  switch_state_e state;
  logic cfg_load;
  logic unlocked;
  logic key_stage;
  logic [3:0] settle_cnt;
  logic access;
  logic wr_xfer;
  logic [15:0] base_addr;
  logic [1:0] alias_sel;
  logic hit_osc;
  logic hit_tun;
  logic hit_ref;
  logic hit_trim;
  logic hit_key;
  logic mapped;
  logic locked;
  logic osc_wr;
  logic pb_wr;
  logic [31:0] osc_rd;
  logic [31:0] osc_new;
  logic [31:0] rd_mux;

  // alias write: plain, clear ones, set ones, toggle ones
  function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd,
                                        input logic [1:0] sel);
    logic [31:0] r;
    r = wd;
    case (sel)
      ALIAS_CLR: r = cur & ~wd;
      ALIAS_SET: r = cur | wd;
      ALIAS_INV: r = cur ^ wd;
      default: r = wd;
    endcase
    return r;
  endfunction

  // address decode; the unlock key register has no aliases
  assign access = psel & penable & pready;
  assign wr_xfer = access & pwrite;
  assign base_addr = {paddr[15:4], 4'h0};
  assign alias_sel = paddr[3:2];
  assign hit_osc = (base_addr == OSC_CTRL_ADDR);
  assign hit_tun = (base_addr == TUNING_ADDR);
  assign hit_ref = (base_addr == REF_CTRL_ADDR);
  assign hit_trim = (base_addr == REF_TRIM_ADDR);
  assign hit_key = (paddr == UNLOCK_ADDR);
  assign mapped = (paddr[1:0] == 2'h0) & (hit_osc | hit_tun | hit_ref | hit_trim | hit_key);

  // lock only bites when switching and monitoring are disabled
  assign locked = ctrl.clock_select_lock & cfg.config_switch_monitor[1];
  assign osc_wr = wr_xfer & hit_osc & unlocked;
  assign osc_new = merge(osc_rd, pwdata, alias_sel);
  assign pb_wr = osc_wr & periph_divisor_ready &
                 (osc_new[POS_PB_DIV +: 2] != ctrl.periph_bus_divisor);

  // oscillator control read image; unlisted positions stay zero
  always_comb begin
    osc_rd = 32'h0000_0000;
    osc_rd[POS_PLL_DIV +: 3] = ctrl.pll_output_divider;
    osc_rd[POS_FAST_DIV +: 3] = ctrl.fast_rc_divider;
    osc_rd[POS_SOSC_READY] = secondary_osc_ready;
    osc_rd[POS_DIV_READY] = periph_divisor_ready;
    osc_rd[POS_PB_DIV +: 2] = ctrl.periph_bus_divisor;
    osc_rd[POS_PLL_MULT +: 3] = ctrl.pll_multiplier;
    osc_rd[POS_CUR_OSC +: 3] = current_oscillator;
    osc_rd[POS_NEW_OSC +: 3] = ctrl.new_oscillator;
    osc_rd[POS_LOCK] = ctrl.clock_select_lock;
    osc_rd[POS_USB_LOCK] = usb_pll_lock_flag;
    osc_rd[POS_SYS_LOCK] = system_pll_lock_flag;
    osc_rd[POS_SLEEP] = ctrl.sleep_on_wait_enable;
    osc_rd[POS_FAIL] = ctrl.clock_fail_flag;
    osc_rd[POS_USB_RC] = ctrl.usb_rc_clock_enable;
    osc_rd[POS_SOSC_ON] = ctrl.secondary_osc_enable;
    osc_rd[POS_SWITCH] = ctrl.switch_enable;
  end

  // read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_osc) begin
      rd_mux = osc_rd;
    end else if (hit_tun) begin
      rd_mux = tuning;
    end else if (hit_ref) begin
      rd_mux = ref_ctrl;
    end else if (hit_trim) begin
      rd_mux = ref_trim;
    end
  end

  // apb slave: one wait state, read data registered with pready
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel & penable & ~pready & ~pwrite & mapped) begin
        prdata <= rd_mux;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // config bits cannot be caught under async reset, so load on the first edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_load <= 1'b1;
    end else begin
      cfg_load <= 1'b0;
    end
  end

  // two-key unlock; the window closes after one protected write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unlocked <= 1'b0;
      key_stage <= 1'b0;
    end else if (wr_xfer & hit_key) begin
      key_stage <= (pwdata == UNLOCK_KEY1);
      if (key_stage & (pwdata == UNLOCK_KEY2)) begin
        unlocked <= 1'b1;
      end
    end else if (wr_xfer) begin
      key_stage <= 1'b0;
      if (hit_osc | hit_tun) begin
        unlocked <= 1'b0;
      end
    end
  end

  // control fields; hardware set of the fail flag beats a software clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= '0;
      ctrl.fast_rc_divider <= FAST_DIV_RESET;
      ctrl.periph_bus_divisor <= PB_DIV_RESET;
    end else if (cfg_load) begin
      ctrl.new_oscillator <= cfg.config_oscillator_select;
      ctrl.fast_rc_divider <= FAST_DIV_RESET;
      if (reset_was_por) begin
        ctrl.pll_output_divider <= cfg.pll_odiv;
        ctrl.pll_multiplier <= cfg.pll_mult;
        ctrl.periph_bus_divisor <= cfg.pb_div;
        ctrl.secondary_osc_enable <= cfg.sosc_en;
      end else begin
        ctrl.pll_output_divider <= PLL_DIV_RESET;
        ctrl.pll_multiplier <= PLL_MULT_RESET;
        ctrl.periph_bus_divisor <= PB_DIV_RESET;
        ctrl.secondary_osc_enable <= 1'b0;
      end
    end else begin
      if (osc_wr) begin
        ctrl.fast_rc_divider <= osc_new[POS_FAST_DIV +: 3];
        ctrl.clock_select_lock <= osc_new[POS_LOCK];
        ctrl.sleep_on_wait_enable <= osc_new[POS_SLEEP];
        ctrl.usb_rc_clock_enable <= osc_new[POS_USB_RC];
        ctrl.secondary_osc_enable <= osc_new[POS_SOSC_ON];
        ctrl.clock_fail_flag <= osc_new[POS_FAIL];
        if (!locked) begin
          ctrl.pll_output_divider <= osc_new[POS_PLL_DIV +: 3];
          ctrl.pll_multiplier <= osc_new[POS_PLL_MULT +: 3];
          if (state == st_idle) begin
            ctrl.new_oscillator <= osc_new[POS_NEW_OSC +: 3];
            if (osc_new[POS_SWITCH]) begin
              ctrl.switch_enable <= 1'b1;
            end
          end
        end
        if (pb_wr) begin
          ctrl.periph_bus_divisor <= osc_new[POS_PB_DIV +: 2];
        end
      end
      if (status.clock_fail_detect) begin
        ctrl.clock_fail_flag <= 1'b1;
      end
      if (state == st_commit) begin
        ctrl.switch_enable <= 1'b0;
      end
    end
  end

  // switch sequencer: wait for the target source, then commit it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      current_oscillator <= CUR_OSC_RESET;
      switch_busy <= 1'b0;
    end else if (cfg_load) begin
      state <= st_idle;
      current_oscillator <= cfg.config_oscillator_select;
      switch_busy <= 1'b0;
    end else begin
      case (state)
        st_idle: begin
          if (ctrl.switch_enable) begin
            state <= st_wait;
            switch_busy <= 1'b1;
          end
        end
        st_wait: begin
          if (status.target_osc_ready) begin
            state <= st_commit;
          end
        end
        st_commit: begin
          current_oscillator <= ctrl.new_oscillator;
          state <= st_idle;
          switch_busy <= 1'b0;
        end
        default: begin
          state <= st_idle;
          switch_busy <= 1'b0;
        end
      endcase
    end
  end

  // divisor busy window so the divider sees at most one divisor change per window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_cnt <= 4'h0;
      periph_divisor_ready <= 1'b1;
    end else if (pb_wr) begin
      settle_cnt <= PB_DIV_SETTLE_CYCLES;
      periph_divisor_ready <= 1'b0;
    end else if (settle_cnt > 4'h1) begin
      settle_cnt <= settle_cnt - 4'h1;
    end else begin
      settle_cnt <= 4'h0;
      periph_divisor_ready <= 1'b1;
    end
  end

  // status flags from the analog side, sampled once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      secondary_osc_ready <= 1'b0;
      usb_pll_lock_flag <= 1'b0;
      system_pll_lock_flag <= 1'b0;
    end else begin
      secondary_osc_ready <= status.sosc_stable & ctrl.secondary_osc_enable;
      usb_pll_lock_flag <= status.usb_pll_locked;
      system_pll_lock_flag <= status.sys_pll_locked;
    end
  end

  // decoded ratios for the clock tree, one cycle behind the codes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pll_out_div_ratio <= 9'h001;
      fast_rc_div_ratio <= 9'h002;
      pll_mult_ratio <= 5'h0F;
    end else begin
      pll_out_div_ratio <= div_ratio(ctrl.pll_output_divider);
      fast_rc_div_ratio <= div_ratio(ctrl.fast_rc_divider);
      pll_mult_ratio <= mult_ratio(ctrl.pll_multiplier);
    end
  end

  // reference, tuning and trim storage; divider switch bit self-clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_ctrl <= 32'h0000_0000;
      tuning <= 32'h0000_0000;
      ref_trim <= 32'h0000_0000;
    end else begin
      if (ref_ctrl[REF_DIVSW_BIT]) begin
        ref_ctrl[REF_DIVSW_BIT] <= 1'b0;
      end
      if (wr_xfer & hit_ref) begin
        ref_ctrl <= merge(ref_ctrl, pwdata, alias_sel) & REF_CTRL_MASK;
      end
      if (wr_xfer & hit_tun & unlocked) begin
        tuning <= merge(tuning, pwdata, alias_sel) & TUNING_MASK;
      end
      if (wr_xfer & hit_trim) begin
        ref_trim <= merge(ref_trim, pwdata, alias_sel) & REF_TRIM_MASK;
      end
    end
  end

  periph_clock_divider u_pdiv (
    .clk(clk),
    .rst(rst),
    .divisor(ctrl.periph_bus_divisor),
    .tick(periph_clk_en)
  );

  apb_ready_a: assert property (@(posedge clk) disable iff (rst)
    (psel && penable && !pready) |=> pready)
    else $error("apb access not answered after one wait state");

  unlock_gate_a: assert property (@(posedge clk) disable iff (rst)
    (wr_xfer && hit_osc && !unlocked && !cfg_load) |=>
      $stable(ctrl.sleep_on_wait_enable) && $stable(ctrl.fast_rc_divider))
    else $error("locked-out write changed control");

  lock_hold_a: assert property (@(posedge clk) disable iff (rst)
    (locked && !cfg_load) |=> $stable(ctrl.new_oscillator) && $stable(ctrl.pll_multiplier))
    else $error("locked selection changed");

  never_locked_a: assert property (@(posedge clk) disable iff (rst)
    !cfg.config_switch_monitor[1] |-> !locked)
    else $error("selection locked with monitor enabled");

  pb_div_block_a: assert property (@(posedge clk) disable iff (rst)
    (!periph_divisor_ready && !cfg_load) |=> $stable(ctrl.periph_bus_divisor))
    else $error("divisor changed while not ready");

  pb_div_busy_a: assert property (@(posedge clk) disable iff (rst)
    pb_wr |=> !periph_divisor_ready [*8] ##1 periph_divisor_ready)
    else $error("divisor busy window wrong length");

  switch_commit_a: assert property (@(posedge clk) disable iff (rst)
    (state == st_commit) |=>
      (current_oscillator == $past(ctrl.new_oscillator)) && !ctrl.switch_enable)
    else $error("switch did not commit new source");

  cur_osc_hold_a: assert property (@(posedge clk) disable iff (rst)
    (state == st_wait && !cfg_load) |=> $stable(current_oscillator))
    else $error("current source changed before completion");

  switch_start_a: assert property (@(posedge clk) disable iff (rst)
    (state == st_idle && ctrl.switch_enable && !cfg_load) |=> switch_busy ##1 1'b1)
    else $error("switch request not started");

  clock_fail_a: assert property (@(posedge clk) disable iff (rst)
    (status.clock_fail_detect && !cfg_load) |=> ctrl.clock_fail_flag)
    else $error("clock failure not flagged");

  sosc_ready_a: assert property (@(posedge clk) disable iff (rst)
    secondary_osc_ready |-> $past(ctrl.secondary_osc_enable) && $past(status.sosc_stable))
    else $error("secondary ready without stable oscillator");

  fast_div_reset_a: assert property (@(posedge clk) disable iff (rst)
    $fell(cfg_load) |-> ctrl.fast_rc_divider == 3'h1)
    else $error("fast rc divider not at divide by two");

  odiv_ratio_a: assert property (@(posedge clk) disable iff (rst)
    (ctrl.pll_output_divider == 3'h7) |=> pll_out_div_ratio == 9'h100)
    else $error("pll output divide ratio wrong");

  mult_ratio_a: assert property (@(posedge clk) disable iff (rst)
    (ctrl.pll_multiplier == 3'h0) |=> pll_mult_ratio == 5'h0F)
    else $error("pll multiplier ratio wrong");

  pclk_div8_a: assert property (@(posedge clk) disable iff (rst)
    (periph_clk_en && ctrl.periph_bus_divisor == 2'h3 && $stable(ctrl.periph_bus_divisor))
      |=> !periph_clk_en [*7])
    else $error("peripheral enable faster than divide by eight");

endmodule

// ### verilog/periph_clock_divider.sv
`timescale 1ns/1ps
module periph_clock_divider (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] divisor,
  output logic tick
);
  logic [2:0] cnt;
  logic [2:0] limit;

  // terminal count for divide by 1, 2, 4 or 8
  always_comb begin
    case (divisor)
      2'h0: limit = 3'h0;
      2'h1: limit = 3'h1;
      2'h2: limit = 3'h3;
      default: limit = 3'h7;
    endcase
  end

  // one-cycle enable per peripheral period; a shrinking divisor wraps at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 3'h0;
      tick <= 1'b0;
    end else if (cnt >= limit) begin
      cnt <= 3'h0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 3'h1;
      tick <= 1'b0;
    end
  end
endmodule
